// >>> filter_if.sv
// Carrier between the sequencer and the persistence filter
`timescale 1ns/10ps
`default_nettype none
interface filter_if;
	logic [15:0] result;
	logic [15:0] low_thr;
	logic [15:0] high_thr;
	logic [3:0]  fail_sel;
	logic        eval;
	logic        fire;

	modport ctrl (output result, output low_thr, output high_thr, output fail_sel,
		output eval, input fire);
	modport filt (input result, input low_thr, input high_thr, input fail_sel,
		input eval, output fire);
endinterface
`default_nettype wire

// >>> host_model.sv
// Host side model driving the register port of the light sensor core
`timescale 1ns/10ps
`default_nettype none
module host_model (
	// Clock
	input  wire logic       clk_sys,
	// Register port
	output logic            cmd_wr,
	output logic            wr_strobe,
	output logic            rd_strobe,
	output logic      [7:0] wr_byte,
	input  wire logic [7:0] rd_byte
);
	// Idle port at time zero
	initial begin
		cmd_wr = 1'b0;
		wr_strobe = 1'b0;
		rd_strobe = 1'b0;
		wr_byte = 8'h00;
	end
	// -------------------------------------------------
	// Port cycles
	// -------------------------------------------------
	// One strobe; the released byte is inverted so no stale value passes
	task automatic pulse(input logic [1:0] kind, input logic [7:0] b);
		@(posedge clk_sys);
		cmd_wr <= (kind == 2'h0);
		wr_strobe <= (kind == 2'h1);
		rd_strobe <= (kind == 2'h2);
		wr_byte <= b;
		@(posedge clk_sys);
		cmd_wr <= 1'b0;
		wr_strobe <= 1'b0;
		rd_strobe <= 1'b0;
		wr_byte <= ~b;
	endtask
	// Repeat-type command then one data byte
	task automatic write_reg(input logic [4:0] a, input logic [7:0] v);
		pulse(2'h0, {3'h4, a});
		pulse(2'h1, v);
	endtask
	// Read data lands one cycle after the strobe edge
	task automatic read_reg(input logic [4:0] a, output logic [7:0] v);
		pulse(2'h0, {3'h4, a});
		pulse(2'h2, 8'h00);
		@(posedge clk_sys);
		v = rd_byte;
	endtask
	// Auto-increment command, then a coherent two-byte read through the shadow
	task automatic read_pair(input logic [4:0] a, output logic [7:0] lo_v, output logic [7:0] hi_v);
		pulse(2'h0, {3'h5, a});
		pulse(2'h2, 8'h00);
		@(posedge clk_sys);
		lo_v = rd_byte;
		pulse(2'h2, 8'h00);
		@(posedge clk_sys);
		hi_v = rd_byte;
	endtask
	// Special function that drops a pending interrupt, once
	task automatic clear_irq();
		pulse(2'h0, 8'he6);
		@(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// >>> light_sensor_core.sv
// Light sensor core: register port, integration and wait sequencing, status
`timescale 1ns/10ps
`default_nettype none
module light_sensor_core
	import light_sensor_pkg::*;
#(
	parameter int         STEP_LEN  = STEP_CYCLES,
	parameter logic [7:0] PART_CODE = 8'h5a // Arbitrary value
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// Register port from the serial engine
	input  wire logic        cmd_wr,
	input  wire logic        wr_strobe,
	input  wire logic        rd_strobe,
	input  wire logic [7:0]  wr_byte,
	output logic      [7:0]  rd_byte,
	// Analog front end
	input  wire logic [10:0] bb_step_count,
	input  wire logic [10:0] ir_step_count,
	output logic             osc_run,
	output logic             integrating,
	output logic      [1:0]  gain_sel,
	// Interrupt pin, open drain
	output logic             irq_o,
	output logic             irq_oe
);
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_INTEG = 3'b010,
		ST_WAIT  = 3'b100
	} seq_state_t;

	seq_state_t  state;
	logic [4:0]  cmd_addr;
	logic [1:0]  cmd_type;
	logic [7:0]  enable_reg;
	logic [7:0]  integration_steps;
	logic [7:0]  wait_steps;
	logic [15:0] low_thr;
	logic [15:0] high_thr;
	logic [3:0]  fail_count_select;
	logic        wait_stretch;
	logic [1:0]  analog_gain_sel;
	logic [15:0] broadband_result;
	logic [15:0] infrared_result;
	logic [15:0] bb_acc;
	logic [15:0] ir_acc;
	logic [15:0] next_bb_acc;
	logic [15:0] next_ir_acc;
	logic [7:0]  bb_shadow;
	logic [7:0]  ir_shadow;
	logic        result_ready;
	logic        light_irq_flag;
	logic        irq_clear;
	logic        run_ok;
	logic        launch;
	logic        eval;
	logic        tmr_tick;
	logic        tmr_done;
	logic [31:0] step_len;
	logic [8:0]  step_count;
	logic [7:0]  rd_value;
	logic        light_engine_on;
	logic        wait_timer_on;
	logic        light_irq_mask;

	filter_if fif ();

	assign light_engine_on = enable_reg[EN_ENGINE_BIT];
	assign wait_timer_on   = enable_reg[EN_WAIT_BIT];
	assign light_irq_mask  = enable_reg[EN_MASK_BIT];
	assign run_ok          = enable_reg[EN_OSC_BIT] && light_engine_on;

	// ------------------------------------------------------------
	// Command register
	// ------------------------------------------------------------
	// Special functions leave the pointer alone; auto-increment wraps at 5 bits
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cmd_addr <= 5'h00;
			cmd_type <= TYPE_REPEAT;
		end else if (cmd_wr) begin
			if (wr_byte[CMD_SEL_BIT] && wr_byte[6:5] != TYPE_SPECIAL) begin
				cmd_addr <= wr_byte[4:0];
				cmd_type <= wr_byte[6:5];
			end
		end else if ((wr_strobe || rd_strobe) && cmd_type == TYPE_AUTO_INC) begin
			cmd_addr <= cmd_addr + 5'h01;
		end
	end

	// One-cycle pulse per command byte, nothing stays latched
	assign irq_clear = cmd_wr && wr_byte[CMD_SEL_BIT] && wr_byte[6:5] == TYPE_SPECIAL
		&& wr_byte[4:0] == SF_IRQ_CLEAR;

	// ------------------------------------------------------------
	// Writable configuration registers
	// ------------------------------------------------------------
	// Reserved bits are not stored, so they read back as zero
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			enable_reg        <= REG_RESET;
			integration_steps <= REG_RESET;
			wait_steps        <= REG_RESET;
			low_thr           <= {REG_RESET, REG_RESET};
			high_thr          <= {REG_RESET, REG_RESET};
			fail_count_select <= REG_RESET[3:0];
			wait_stretch      <= 1'b0;
			analog_gain_sel   <= REG_RESET[1:0];
		end else if (wr_strobe) begin
			case (cmd_addr)
				ENABLE_ADDR:      enable_reg        <= wr_byte & 8'h1b;
				INTEG_TIME_ADDR:  integration_steps <= wr_byte;
				WAIT_TIME_ADDR:   wait_steps        <= wr_byte;
				LOW_THR_LO_ADDR:  low_thr[7:0]      <= wr_byte;
				LOW_THR_HI_ADDR:  low_thr[15:8]     <= wr_byte;
				HIGH_THR_LO_ADDR: high_thr[7:0]     <= wr_byte;
				HIGH_THR_HI_ADDR: high_thr[15:8]    <= wr_byte;
				FILTER_ADDR:      fail_count_select <= wr_byte[3:0];
				WAIT_SCALE_ADDR:  wait_stretch      <= wr_byte[STRETCH_BIT];
				GAIN_ADDR:        analog_gain_sel   <= wr_byte[1:0];
				// Part code, flags and results ignore writes
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Upper result bytes come from the shadow so a two-byte read is coherent
	always_comb begin
		case (cmd_addr)
			ENABLE_ADDR:      rd_value = enable_reg;
			INTEG_TIME_ADDR:  rd_value = integration_steps;
			WAIT_TIME_ADDR:   rd_value = wait_steps;
			LOW_THR_LO_ADDR:  rd_value = low_thr[7:0];
			LOW_THR_HI_ADDR:  rd_value = low_thr[15:8];
			HIGH_THR_LO_ADDR: rd_value = high_thr[7:0];
			HIGH_THR_HI_ADDR: rd_value = high_thr[15:8];
			FILTER_ADDR:      rd_value = {4'h0, fail_count_select};
			WAIT_SCALE_ADDR:  rd_value = {6'h00, wait_stretch, 1'b0};
			GAIN_ADDR:        rd_value = {6'h00, analog_gain_sel};
			PART_CODE_ADDR:   rd_value = PART_CODE;
			FLAGS_ADDR:       rd_value = {3'h0, light_irq_flag, 3'h0, result_ready};
			BB_LO_ADDR:       rd_value = broadband_result[7:0];
			BB_HI_ADDR:       rd_value = bb_shadow;
			IR_LO_ADDR:       rd_value = infrared_result[7:0];
			IR_HI_ADDR:       rd_value = ir_shadow;
			default:          rd_value = 8'h00;
		endcase
	end

	// Read data and shadow capture
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rd_byte   <= 8'h00;
			bb_shadow <= 8'h00;
			ir_shadow <= 8'h00;
		end else if (rd_strobe) begin
			rd_byte <= rd_value;
			if (cmd_addr == BB_LO_ADDR) begin
				bb_shadow <= broadband_result[15:8];
			end
			if (cmd_addr == IR_LO_ADDR) begin
				ir_shadow <= infrared_result[15:8];
			end
		end
	end

	// ------------------------------------------------------------
	// Integration and wait sequencer
	// ------------------------------------------------------------
	// Wait enable is sampled at the end of each integration only
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state  <= ST_IDLE;
			launch <= 1'b0;
		end else begin
			launch <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (run_ok) begin
						state  <= ST_INTEG;
						launch <= 1'b1;
					end
				end
				ST_INTEG: begin
					if (!run_ok) begin
						state <= ST_IDLE;
					end else if (tmr_done) begin
						state  <= wait_timer_on ? ST_WAIT : ST_INTEG;
						launch <= 1'b1;
					end
				end
				ST_WAIT: begin
					if (!run_ok) begin
						state <= ST_IDLE;
					end else if (tmr_done) begin
						state  <= ST_INTEG;
						launch <= 1'b1;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Step count is 256 minus the register, so zero means 256
	assign step_count = (state == ST_WAIT) ? STEP_SPAN - {1'b0, wait_steps}
		: STEP_SPAN - {1'b0, integration_steps};
	// Stretched wait steps are twelve plain steps long
	assign step_len = (state == ST_WAIT && wait_stretch)
		? 32'(STEP_LEN * WAIT_STRETCH_MUL) : 32'(STEP_LEN);

	step_timer u_timer (
		.clk_sys     (clk_sys),
		.sys_rst     (sys_rst),
		.start       (launch),
		.abort       (!run_ok),
		.step_cycles (step_len),
		.steps       (step_count),
		.tick        (tmr_tick),
		.done        (tmr_done)
	);

	// ------------------------------------------------------------
	// Accumulators
	// ------------------------------------------------------------
	// Each step adds at most the cap, the sum saturates at full scale
	function automatic logic [15:0] acc_add(input logic [15:0] acc, input logic [10:0] cnt);
		logic [10:0] capped;
		logic [16:0] sum;
		capped = (cnt > STEP_COUNT_CAP) ? STEP_COUNT_CAP : cnt;
		sum    = {1'b0, acc} + {6'h00, capped};
		return sum[16] ? RESULT_MAX : sum[15:0];
	endfunction

	assign next_bb_acc = (tmr_tick && state == ST_INTEG) ? acc_add(bb_acc, bb_step_count) : bb_acc;
	assign next_ir_acc = (tmr_tick && state == ST_INTEG) ? acc_add(ir_acc, ir_step_count) : ir_acc;

	// Results move to the data registers when integration ends
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			bb_acc           <= 16'h0000;
			ir_acc           <= 16'h0000;
			broadband_result <= 16'h0000;
			infrared_result  <= 16'h0000;
			eval             <= 1'b0;
		end else begin
			eval <= 1'b0;
			if (launch || !run_ok) begin
				bb_acc <= 16'h0000;
				ir_acc <= 16'h0000;
			end else if (tmr_done && state == ST_INTEG) begin
				broadband_result <= next_bb_acc;
				infrared_result  <= next_ir_acc;
				bb_acc           <= 16'h0000;
				ir_acc           <= 16'h0000;
				eval             <= 1'b1;
			end else begin
				bb_acc <= next_bb_acc;
				ir_acc <= next_ir_acc;
			end
		end
	end

	// Valid sets once both channels have completed and clears while the engine is disabled
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			result_ready <= 1'b0;
		end else if (eval) begin
			result_ready <= 1'b1;
		end else if (!light_engine_on) begin
			result_ready <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Threshold filter and interrupt
	// ------------------------------------------------------------
	assign fif.result   = broadband_result;
	assign fif.low_thr  = low_thr;
	assign fif.high_thr = high_thr;
	assign fif.fail_sel = fail_count_select;
	assign fif.eval     = eval;

	persistence_filter u_filter (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.fif     (fif.filt)
	);

	// A qualified event in the clear cycle wins, so it is never lost
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			light_irq_flag <= 1'b0;
		end else if (fif.fire && light_irq_mask) begin
			light_irq_flag <= 1'b1;
		end else if (irq_clear) begin
			light_irq_flag <= 1'b0;
		end
	end

	// Pin is pulled low while the flag stands, as a level
	assign irq_o       = 1'b0;
	assign irq_oe      = light_irq_flag;
	assign osc_run     = enable_reg[EN_OSC_BIT];
	assign integrating = (state == ST_INTEG);
	assign gain_sel    = analog_gain_sel;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_clear_cmd;
		irq_clear && !(fif.fire && light_irq_mask);
	endsequence
	sequence s_flag_down;
		!light_irq_flag ##1 !light_irq_flag;
	endsequence

	a_irq_clear_once: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_clear_cmd ##0 !fif.fire ##1 !(fif.fire && light_irq_mask) |-> s_flag_down)
		else $error("interrupt not cleared by command");
	a_irq_level_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		light_irq_flag && !irq_clear |=> light_irq_flag)
		else $error("interrupt dropped without clear");
	a_irq_mask_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!light_irq_flag && !(fif.fire && light_irq_mask) |=> !light_irq_flag)
		else $error("interrupt set while masked");
	a_flag_status_bit: assert property (@(posedge clk_sys) disable iff (sys_rst)
		rd_strobe && cmd_addr == FLAGS_ADDR |=>
		rd_byte == {3'h0, $past(light_irq_flag), 3'h0, $past(result_ready)})
		else $error("status byte mismatch");
	a_part_code_ro: assert property (@(posedge clk_sys) disable iff (sys_rst)
		rd_strobe && cmd_addr == PART_CODE_ADDR |=> rd_byte == PART_CODE)
		else $error("part code changed");
	a_ready_after_integ: assert property (@(posedge clk_sys) disable iff (sys_rst)
		tmr_done && state == ST_INTEG && run_ok |=> ##1 result_ready)
		else $error("valid flag not set after integration");
	a_wait_gated: assert property (@(posedge clk_sys) disable iff (sys_rst)
		tmr_done && state == ST_INTEG && run_ok && !wait_timer_on |=> state == ST_INTEG)
		else $error("wait entered while disabled");
	a_stretch_len: assert property (@(posedge clk_sys) disable iff (sys_rst)
		state == ST_WAIT |-> step_len == (wait_stretch ? 32'(STEP_LEN * 12) : 32'(STEP_LEN)))
		else $error("wait step length wrong");
	a_step_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
		state == ST_WAIT && wait_steps == 8'h00 |-> step_count == 9'h100)
		else $error("wait count not two's complement");
	a_irq_pin: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(light_irq_flag) |-> irq_oe && !irq_o)
		else $error("interrupt pin not driven");
endmodule
`default_nettype wire

// >>> light_sensor_pkg.sv
// Shared constants for the light sensor timing, threshold and status logic
package light_sensor_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [4:0] ENABLE_ADDR       = 5'h00;
	localparam logic [4:0] INTEG_TIME_ADDR   = 5'h01;
	localparam logic [4:0] WAIT_TIME_ADDR    = 5'h03;
	localparam logic [4:0] LOW_THR_LO_ADDR   = 5'h04;
	localparam logic [4:0] LOW_THR_HI_ADDR   = 5'h05;
	localparam logic [4:0] HIGH_THR_LO_ADDR  = 5'h06;
	localparam logic [4:0] HIGH_THR_HI_ADDR  = 5'h07;
	localparam logic [4:0] FILTER_ADDR       = 5'h0c;
	localparam logic [4:0] WAIT_SCALE_ADDR   = 5'h0d;
	localparam logic [4:0] GAIN_ADDR         = 5'h0f;
	localparam logic [4:0] PART_CODE_ADDR    = 5'h12;
	localparam logic [4:0] FLAGS_ADDR        = 5'h13;
	localparam logic [4:0] BB_LO_ADDR        = 5'h14;
	localparam logic [4:0] BB_HI_ADDR        = 5'h15;
	localparam logic [4:0] IR_LO_ADDR        = 5'h16;
	localparam logic [4:0] IR_HI_ADDR        = 5'h17;

	// ------------------------------------------------------------
	// Command byte layout and codes
	// ------------------------------------------------------------
	localparam int         CMD_SEL_BIT    = 7;
	localparam logic [1:0] TYPE_REPEAT    = 2'h0;
	localparam logic [1:0] TYPE_AUTO_INC  = 2'h1;
	localparam logic [1:0] TYPE_SPECIAL   = 2'h3;
	localparam logic [4:0] SF_IRQ_CLEAR   = 5'h06;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int         EN_OSC_BIT     = 0;
	localparam int         EN_ENGINE_BIT  = 1;
	localparam int         EN_WAIT_BIT    = 3;
	localparam int         EN_MASK_BIT    = 4;
	localparam int         STRETCH_BIT    = 1;
	localparam int         FLAG_IRQ_BIT   = 4;
	localparam int         FLAG_READY_BIT = 0;
	localparam logic [7:0] REG_RESET      = 8'h00;

	// ------------------------------------------------------------
	// Timing and result limits
	// ------------------------------------------------------------
	localparam int           CLK_PERIOD_NS    = 20;
	localparam int           STEP_TIME_NS     = 2720000;
	localparam int           STEP_CYCLES      = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int           WAIT_STRETCH_MUL = 12;
	localparam logic [8:0]   STEP_SPAN        = 9'h100;
	localparam logic [10:0]  STEP_COUNT_CAP   = 11'h400;
	localparam logic [15:0]  RESULT_MAX       = 16'hffff;

endpackage

// >>> persistence_filter.sv
// Threshold compare and consecutive out-of-range filter
`timescale 1ns/10ps
`default_nettype none
module persistence_filter
	import light_sensor_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	// Filter carrier
	filter_if.filt    fif
);
	logic [5:0] run_cnt;
	logic [5:0] need;
	logic [5:0] run_next;
	logic       out_of_range;

	// Out of range is strictly below low or strictly above high
	assign out_of_range = (fif.result < fif.low_thr) || (fif.result > fif.high_thr);

	// Selections 1..3 map directly, above that in steps of five
	// Widen before the product, a four-bit product would wrap above selection 6
	assign need = (fif.fail_sel < 4'h4) ? {2'h0, fif.fail_sel}
		: ({2'h0, fif.fail_sel} - 6'h03) * 6'h05;
	assign run_next = (run_cnt == 6'h3f) ? run_cnt : run_cnt + 6'h1;

	// ------------------------------------------------------------
	// Run counter and fire pulse
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			run_cnt  <= 6'h0;
			fif.fire <= 1'b0;
		end else begin
			fif.fire <= 1'b0;
			if (fif.eval) begin
				if (fif.fail_sel == 4'h0) begin
					fif.fire <= 1'b1;
				end
				if (out_of_range) begin
					run_cnt <= run_next;
					if (fif.fail_sel != 4'h0 && run_next >= need) begin
						fif.fire <= 1'b1;
					end
				end else begin
					run_cnt <= 6'h0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_every_cycle_fire: assert property (@(posedge clk_sys) disable iff (sys_rst)
		fif.eval && fif.fail_sel == 4'h0 |=> fif.fire)
		else $error("no fire on every-cycle selection");
	a_first_out_fire: assert property (@(posedge clk_sys) disable iff (sys_rst)
		fif.eval && fif.fail_sel == 4'h1 && out_of_range |=> fif.fire)
		else $error("no fire on first out-of-range result");
	a_inrange_run_reset: assert property (@(posedge clk_sys) disable iff (sys_rst)
		fif.eval && !out_of_range |=> run_cnt == 6'h0 && (fif.fire == ($past(fif.fail_sel) == 4'h0)))
		else $error("in-range result did not reset run");
	a_no_eval_no_fire: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!fif.eval |=> !fif.fire)
		else $error("fire without an evaluation");
endmodule
`default_nettype wire

// >>> step_timer.sv
// Step timer: counts a number of steps, each of a programmable cycle length
`timescale 1ns/10ps
`default_nettype none
module step_timer
	import light_sensor_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// Control
	input  wire logic        start,
	input  wire logic        abort,
	input  wire logic [31:0] step_cycles,
	input  wire logic [8:0]  steps,
	// Status
	output logic             tick,
	output logic             done
);
	logic [31:0] presc;
	logic [8:0]  left;
	logic        busy;

	// ------------------------------------------------------------
	// Prescaler and step counter
	// ------------------------------------------------------------
	// A step ends when the prescaler reaches the last cycle of its span
	always_ff @(posedge clk_sys) begin
		tick <= 1'b0;
		done <= 1'b0;
		if (sys_rst || abort) begin
			busy  <= 1'b0;
			presc <= 32'h0;
			left  <= 9'h0;
		end else if (start) begin
			busy  <= 1'b1;
			presc <= 32'h0;
			left  <= steps;
		end else if (busy) begin
			if (presc >= step_cycles - 32'h1) begin
				presc <= 32'h0;
				tick  <= 1'b1;
				left  <= left - 9'h1;
				if (left == 9'h1) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end else begin
				presc <= presc + 32'h1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench of the light sensor core
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import light_sensor_pkg::*;
	logic        clk_sys, sys_rst, cmd_wr, wr_strobe, rd_strobe;
	logic [7:0]  wr_byte, rd_byte, d, lo;
	logic [10:0] bb, ir;
	logic        osc_run, integrating, irq_o, irq_oe;
	logic [1:0]  gain_sel;
	int          fail_count, comparisons, c, s, n, k, r;
	// Wait rows: enable, wait count, scale, shortest and longest gap
	int          tw [4][5] = '{'{8'h13, 8'hff, 2, 0, 8}, '{8'h1b, 8'hff, 2, 48, 54},
		'{8'h1b, 8'hff, 0, 4, 9}, '{8'h1b, 8'h00, 0, 1024, 1030}};
	host_model i_host (.clk_sys(clk_sys), .cmd_wr(cmd_wr), .wr_strobe(wr_strobe),
		.rd_strobe(rd_strobe), .wr_byte(wr_byte), .rd_byte(rd_byte));
	light_sensor_core #(.STEP_LEN(4), .PART_CODE(8'h3c)) i_dut (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .cmd_wr(cmd_wr), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
		.wr_byte(wr_byte), .rd_byte(rd_byte), .bb_step_count(bb), .ir_step_count(ir),
		.osc_run(osc_run), .integrating(integrating), .gain_sel(gain_sel), .irq_o(irq_o),
		.irq_oe(irq_oe));
	// 50 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// -------------------------------------------------
	// Helpers
	// -------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Next end of integration, then room for eval, fire and pin
	task automatic wait_end();
		k = 0;
		// Without wait the engine chains integrations, so watch the end pulse
		while (i_dut.eval !== 1'b1 && k < 2000) begin @(posedge clk_sys); k++; end
		if (k >= 2000) check("integration end", 16'h0, 16'h1);
		repeat (4) @(posedge clk_sys);
	endtask
	function automatic logic [15:0] exp_sum(input int cnt, input int steps);
		int t;
		t = ((cnt > 1024) ? 1024 : cnt) * steps;
		return (t > 65535) ? 16'hffff : 16'(t);
	endfunction
	function automatic logic [15:0] exp_run(input int sel);
		return (sel < 4) ? 16'(sel) : 16'(5 * (sel - 3));
	endfunction
	// Watchdog sized well past the longest expected run, about 50k cycles
	initial begin
		#1ms;
		fail_count++;
		stop_test();
	end
	// -------------------------------------------------
	// Main sequence
	// -------------------------------------------------
	initial begin
		r = $urandom(84574);
		bb = 11'h000;
		ir = 11'h000;
		sys_rst = 1'b1;
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		i_host.write_reg(PART_CODE_ADDR, 8'ha5);
		i_host.write_reg(FLAGS_ADDR, 8'hff);
		i_host.read_reg(PART_CODE_ADDR, d);
		check("part code", d, 16'h3c);
		i_host.read_reg(FLAGS_ADDR, d);
		check("flags after write", d, 16'h00);
		for (s = 0; s < 4; s++) begin
			lo = 8'($urandom);
			i_host.write_reg(LOW_THR_LO_ADDR + 5'(s), lo);
			i_host.read_reg(LOW_THR_LO_ADDR + 5'(s), d);
			check("threshold byte", d, lo);
		end
		lo = {6'h00, 2'($urandom)};
		i_host.write_reg(GAIN_ADDR, lo);
		@(posedge clk_sys);
		check("gain select", gain_sel, lo[1:0]);
		// In-range window, two steps, wait set up before the engine starts
		i_host.write_reg(LOW_THR_LO_ADDR, 8'h00);
		i_host.write_reg(LOW_THR_HI_ADDR, 8'h00);
		i_host.write_reg(HIGH_THR_LO_ADDR, 8'hff);
		i_host.write_reg(HIGH_THR_HI_ADDR, 8'hff);
		i_host.write_reg(INTEG_TIME_ADDR, 8'hfe);
		i_host.write_reg(WAIT_TIME_ADDR, 8'hff);
		i_host.write_reg(WAIT_SCALE_ADDR, 8'h02);
		i_host.write_reg(ENABLE_ADDR, 8'h03);
		@(posedge clk_sys);
		check("osc run", osc_run, 16'h1);
		// Third pass: 64 full-scale steps must saturate the result
		for (s = 0; s < 3; s++) begin
			c = s ? 2047 : $urandom_range(1023, 200);
			if (s == 2) i_host.write_reg(INTEG_TIME_ADDR, 8'hc0);
			@(posedge clk_sys);
			bb <= 11'(c);
			ir <= ~11'(c);
			wait_end();
			wait_end();
			i_host.read_pair(BB_LO_ADDR, lo, d);
			check("broadband result", {d, lo}, exp_sum(c, (s == 2) ? 64 : 2));
		end
		i_host.write_reg(INTEG_TIME_ADDR, 8'hfe);
		check("masked pin", irq_oe, 16'h0);
		i_host.read_reg(FLAGS_ADDR, d);
		check("valid flag", d, 16'h01);
		i_host.write_reg(ENABLE_ADDR, 8'h13);
		wait_end();
		check("every cycle pin", irq_oe, 16'h1);
		check("pin data", irq_o, 16'h0);
		i_host.read_reg(FLAGS_ADDR, d);
		check("irq flag", d, 16'h11);
		// Persistence codes 1 to 15; an in-range result must restart the run
		for (s = 1; s < 16; s++) begin
			i_host.write_reg(HIGH_THR_HI_ADDR, 8'hff);
			wait_end();
			wait_end();
			if (s > 1) check("held level", irq_oe, 16'h1);
			// Engine off first, so no late every-cycle fire lands after the clear
			i_host.write_reg(ENABLE_ADDR, 8'h01);
			i_host.clear_irq();
			check("cleared pin", irq_oe, 16'h0);
			i_host.write_reg(FILTER_ADDR, 8'(s));
			i_host.write_reg(HIGH_THR_HI_ADDR, 8'h01);
			i_host.write_reg(ENABLE_ADDR, 8'h13);
			n = 0;
			while (irq_oe !== 1'b1 && n < 70) begin wait_end(); n++; end
			check("run length", 16'(n), exp_run(s));
		end
		// Gap between integrations for each wait setting
		for (s = 0; s < 4; s++) begin
			i_host.write_reg(WAIT_TIME_ADDR, 8'(tw[s][1]));
			i_host.write_reg(WAIT_SCALE_ADDR, 8'(tw[s][2]));
			i_host.write_reg(ENABLE_ADDR, 8'(tw[s][0]));
			wait_end();
			wait_end();
			n = 4;
			while (integrating !== 1'b1 && n < 2000) begin @(posedge clk_sys); n++; end
			check("wait gap", 16'(n >= tw[s][3] && n <= tw[s][4]), 16'h1);
		end
		stop_test();
	end
endmodule
`default_nettype wire
